// ---- rtl/cir_pkg.sv ----
// Package: register selects, field layout and timing for the card information register set
package cir_pkg;
    // ------------------------------------------------------------
    // Register widths
    // ------------------------------------------------------------
    localparam int OPCOND_W = 32;
    localparam int IDENT_W = 128;
    localparam int SPECIFIC_W = 128;
    localparam int ADDR_W = 16;
    localparam int DRIVER_W = 16;
    localparam int CONFIG_W = 64;
    localparam int STATUS_W = 512;
    localparam int READ_W = STATUS_W;

    // ------------------------------------------------------------
    // Read selects
    // ------------------------------------------------------------
    localparam logic [2:0] SEL_OPCOND = 3'h0;
    localparam logic [2:0] SEL_IDENT = 3'h1;
    localparam logic [2:0] SEL_SPECIFIC = 3'h2;
    localparam logic [2:0] SEL_ADDR = 3'h3;
    localparam logic [2:0] SEL_DRIVER = 3'h4;
    localparam logic [2:0] SEL_CONFIG = 3'h5;
    localparam logic [2:0] SEL_STATUS = 3'h6;

    // ------------------------------------------------------------
    // Operating-conditions word layout
    // ------------------------------------------------------------
    localparam int OC_WIN_LSB = 15;
    localparam int OC_WIN_MSB = 23;
    localparam int OC_WIN_W = 9;
    localparam int OC_LOWV_BIT = 7;
    localparam int OC_CAP_BIT = 30;
    localparam int OC_PWRUP_BIT = 31;
    localparam logic [31:0] OC_RESERVED_MASK = 32'h3F007FFF;

    // ------------------------------------------------------------
    // Identification word layout
    // ------------------------------------------------------------
    localparam int ID_MAKER_LSB = 120;
    localparam int ID_OEM_LSB = 104;
    localparam int ID_NAME_LSB = 64;
    localparam int ID_REV_LSB = 56;
    localparam int ID_SERIAL_LSB = 24;
    localparam int ID_RSVD_LSB = 20;
    localparam int ID_DATE_LSB = 8;
    localparam int ID_CRC_LSB = 1;
    localparam int ID_BODY_W = 120;
    localparam logic [6:0] CRC7_POLY = 7'h09;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int PWRUP_TIME_NS = 40000;
    localparam int PWRUP_CYCLES = (PWRUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Power-up routine states
    typedef enum logic [1:0] {
        CIR_ST_CRC = 2'b00,
        CIR_ST_WAIT = 2'b01,
        CIR_ST_READY = 2'b11
    } cir_state_t;
endpackage

// ---- rtl/cir_crc7.sv ----
// Serial seven-bit checksum engine over a fixed-width word, MSB first
`timescale 1ns/1ps
`default_nettype none
module cir_crc7
    import cir_pkg::*;
#(
    parameter int DATA_W = ID_BODY_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [DATA_W-1:0] data,
    output logic [6:0] crc,
    output logic done
);
    logic [7:0] idx;
    logic busy;
    wire fb = data[idx[6:0]] ^ crc[6];
    wire [6:0] next_crc = {crc[5:0], 1'b0} ^ (fb ? CRC7_POLY : 7'h00);
    wire last = (idx == 8'h00);

    // ------------------------------------------------------------
    // Shift one bit per clock from the top of the word down
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            idx <= 8'h00;
            busy <= 1'b0;
            crc <= 7'h00;
            done <= 1'b0;
        end else if (start) begin
            idx <= 8'(DATA_W - 1);
            busy <= 1'b1;
            crc <= 7'h00;
            done <= 1'b0;
        end else if (busy) begin
            crc <= next_crc;
            idx <= idx - 8'h01;
            busy <= !last;
            done <= last;
        end else begin
            done <= 1'b0; // Done is a one-cycle pulse
        end
    end
endmodule
`default_nettype wire

// ---- rtl/cir_regs.sv ----
// Card information register set: operating conditions, identification and read port
//
// Behaviour
// - The set offers a 32-bit conditions word, 128-bit identity and specific-data words, a 16-bit address word, 64-bit configuration and 512-bit status words.
// - The driver-stage word is not implemented and a read of it is answered as absent.
// - Conditions bits 15 to 23 each flag one 0.1 V supply window from 2.7-2.8 V up to 3.5-3.6 V.
// - Conditions bits 0 to 6, 8 to 14 and 24 to 29 are reserved and bit 7 stays reserved for a low-voltage range.
// - Conditions bit 31 is low while the power-up routine runs and set once it completes.
// - Conditions bit 30 reports capacity and only means something once bit 31 is set.
// - A 128-bit identity word carries a serial number unique to each card.
// - The identity word holds maker, OEM, name, revision, serial, reserved, date, checksum and a fixed one in bit 0.
`timescale 1ns/1ps
`default_nettype none
module cir_regs
    import cir_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE = 8'h5A,       // Arbitrary value
    parameter logic [15:0] OEM_CODE = 16'h4142,     // Arbitrary value
    parameter logic [39:0] PRODUCT_NAME = 40'h4341524430,
    parameter logic [7:0] PRODUCT_REV = 8'h10,
    parameter logic [31:0] PRODUCT_SERIAL = 32'h00000001,
    parameter logic [11:0] MANUFACTURE_DATE = 12'h011,
    parameter logic [OC_WIN_W-1:0] VOLT_WINDOW = 9'h1FF,
    parameter int PWRUP_COUNT = PWRUP_CYCLES,
    parameter logic [SPECIFIC_W-1:0] SPECIFIC_DATA = 128'h0,
    parameter logic [ADDR_W-1:0] CARD_ADDR = 16'h0000,
    parameter logic [CONFIG_W-1:0] CONFIG_DATA = 64'h0,
    parameter logic [STATUS_W-1:0] STATUS_DATA = 512'h0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic capacity_pin,
    input wire logic rd_req,
    input wire logic [2:0] rd_sel,
    output logic rd_valid,
    output logic rd_absent,
    output logic [READ_W-1:0] rd_data,
    output logic card_ready
);
    // ------------------------------------------------------------
    // Capacity strap synchroniser
    // ------------------------------------------------------------
    logic cap_s1, cap_s2, cap_s3, cap_level;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cap_s1 <= 1'b0;
            cap_s2 <= 1'b0;
            cap_s3 <= 1'b0;
            cap_level <= 1'b0;
        end else begin
            cap_s1 <= capacity_pin;
            cap_s2 <= cap_s1;
            cap_s3 <= cap_s2;
            if (cap_s2 == cap_s3) begin
                cap_level <= cap_s3;
            end
        end
    end

    // ------------------------------------------------------------
    // Identification word body and checksum
    // ------------------------------------------------------------
    wire [ID_BODY_W-1:0] ident_body = {MAKER_CODE, OEM_CODE, PRODUCT_NAME, PRODUCT_REV,
                                       PRODUCT_SERIAL, 4'h0, MANUFACTURE_DATE};
    logic crc_start;
    logic crc_done;
    logic [6:0] crc_value;
    logic [6:0] ident_crc;

    cir_crc7 #(.DATA_W(ID_BODY_W)) u_crc (
        .clk(clk),
        .rst(rst),
        .start(crc_start),
        .data(ident_body),
        .crc(crc_value),
        .done(crc_done)
    );

    // ------------------------------------------------------------
    // Power-up routine: checksum, then settle delay
    // ------------------------------------------------------------
    cir_state_t state, next_state;
    logic [15:0] wait_cnt;
    logic started;
    logic capacity;
    wire wait_over = (wait_cnt == 16'(PWRUP_COUNT - 1));

    always_comb begin
        next_state = state;
        unique case (state)
            CIR_ST_CRC: if (crc_done) next_state = CIR_ST_WAIT;
            CIR_ST_WAIT: if (wait_over) next_state = CIR_ST_READY;
            CIR_ST_READY: next_state = CIR_ST_READY;
            default: next_state = CIR_ST_CRC;
        endcase
    end

    // State, counter, checksum latch and capacity capture
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= CIR_ST_CRC;
            wait_cnt <= 16'h0000;
            started <= 1'b0;
            crc_start <= 1'b0;
            ident_crc <= 7'h00;
            card_ready <= 1'b0;
            capacity <= 1'b0;
        end else begin
            state <= next_state;
            started <= 1'b1;
            crc_start <= !started;
            if (crc_done) ident_crc <= crc_value;
            wait_cnt <= (state == CIR_ST_WAIT) ? wait_cnt + 16'h0001 : 16'h0000;
            card_ready <= (next_state == CIR_ST_READY);
            if (next_state == CIR_ST_READY && state != CIR_ST_READY) capacity <= cap_level;
        end
    end

    // ------------------------------------------------------------
    // Read-only words assembled from constants and status
    // ------------------------------------------------------------
    wire [OPCOND_W-1:0] opcond_word = {card_ready, capacity & card_ready, 6'h00,
                                       VOLT_WINDOW, 15'h0000};
    wire [IDENT_W-1:0] ident_word = {ident_body, ident_crc, 1'b1};

    // Read selection, zero-extended into the widest word
    wire [READ_W-1:0] sel_data =
        (rd_sel == SEL_OPCOND) ? READ_W'(opcond_word) :
        (rd_sel == SEL_IDENT) ? READ_W'(ident_word) :
        (rd_sel == SEL_SPECIFIC) ? READ_W'(SPECIFIC_DATA) :
        (rd_sel == SEL_ADDR) ? READ_W'(CARD_ADDR) :
        (rd_sel == SEL_CONFIG) ? READ_W'(CONFIG_DATA) :
        (rd_sel == SEL_STATUS) ? STATUS_DATA : '0;
    wire sel_absent = (rd_sel == SEL_DRIVER) || (rd_sel == 3'h7);

    // ------------------------------------------------------------
    // Read port: answer one cycle after the request
    // ------------------------------------------------------------
    logic [2:0] last_sel;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_valid <= 1'b0;
            rd_absent <= 1'b0;
            rd_data <= '0;
            last_sel <= 3'h0;
        end else begin
            rd_valid <= rd_req;
            if (rd_req) begin
                rd_absent <= sel_absent;
                rd_data <= sel_data;
                last_sel <= rd_sel;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    function automatic logic [6:0] crc7_of(input logic [ID_BODY_W-1:0] d);
        logic [6:0] c;
        logic f;
        c = 7'h00;
        for (int i = ID_BODY_W - 1; i >= 0; i--) begin
            f = d[i] ^ c[6];
            c = {c[5:0], 1'b0} ^ (f ? CRC7_POLY : 7'h00);
        end
        return c;
    endfunction

    sequence s_req(logic [2:0] s);
        rd_req && rd_sel == s;
    endsequence
    sequence s_ans;
        rd_valid;
    endsequence

    property p_widths;
        @(posedge clk) disable iff (rst) s_req(SEL_IDENT) ##1 s_ans |-> rd_data[READ_W-1:IDENT_W] == '0;
    endproperty
    a_widths: assert property (p_widths) else $error("identity read wider than 128 bits");

    property p_driver_absent;
        @(posedge clk) disable iff (rst) s_req(SEL_DRIVER) |=> s_ans and (rd_absent && rd_data == '0);
    endproperty
    a_driver_absent: assert property (p_driver_absent) else $error("driver word not answered as absent");

    property p_window;
        @(posedge clk) disable iff (rst)
            s_req(SEL_OPCOND) |=> rd_data[OC_WIN_MSB:OC_WIN_LSB] == VOLT_WINDOW;
    endproperty
    a_window: assert property (p_window) else $error("voltage window bits wrong");

    property p_reserved;
        @(posedge clk) disable iff (rst)
            rd_valid && last_sel == SEL_OPCOND |-> (rd_data[31:0] & OC_RESERVED_MASK) == 32'h0
                && rd_data[OC_LOWV_BIT] == 1'b0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved conditions bit set");

    property p_busy;
        @(posedge clk) disable iff (rst)
            s_req(SEL_OPCOND) |=> rd_data[OC_PWRUP_BIT] == $past(card_ready);
    endproperty
    a_busy: assert property (p_busy) else $error("power-up flag does not follow routine");

    property p_ready_after_wait;
        @(posedge clk) disable iff (rst) $rose(card_ready) |-> $past(state) == CIR_ST_WAIT && $past(wait_over);
    endproperty
    a_ready_after_wait: assert property (p_ready_after_wait) else $error("ready before routine end");

    property p_capacity;
        @(posedge clk) disable iff (rst) rd_valid && last_sel == SEL_OPCOND && rd_data[OC_CAP_BIT]
            |-> rd_data[OC_PWRUP_BIT];
    endproperty
    a_capacity: assert property (p_capacity) else $error("capacity flag shown while busy");

    property p_ident_fields;
        @(posedge clk) disable iff (rst) s_req(SEL_IDENT) |=> rd_data[0] == 1'b1
            && rd_data[55:24] == PRODUCT_SERIAL && rd_data[127:120] == MAKER_CODE && rd_data[23:20] == 4'h0;
    endproperty
    a_ident_fields: assert property (p_ident_fields) else $error("identity field layout wrong");

    property p_crc;
        @(posedge clk) disable iff (rst)
            (card_ready ##0 s_req(SEL_IDENT)) |=> rd_data[7:1] == crc7_of(ident_body);
    endproperty
    a_crc: assert property (p_crc) else $error("identity checksum wrong");

    property p_read_only;
        @(posedge clk) disable iff (rst) card_ready && $past(card_ready) |-> $stable(ident_crc) && $stable(capacity);
    endproperty
    a_read_only: assert property (p_read_only) else $error("read-only word changed");
endmodule
`default_nettype wire

// ---- verification/cir_host_model.sv ----
// Host controller model that issues reads on the register read port
`timescale 1ns/1ps
`default_nettype none
module cir_host_model
    import cir_pkg::*;
(
    input wire logic clk,
    input wire logic rd_valid,
    input wire logic rd_absent,
    input wire logic [READ_W-1:0] rd_data,
    output logic rd_req,
    output logic [2:0] rd_sel
);
    // ----------------------------------------
    // Idle levels
    // ----------------------------------------
    initial begin
        rd_req = 1'b0;
        rd_sel = 3'h0;
    end

    // ----------------------------------------
    // One read: request for one cycle, then a bounded wait for the strobe
    // ----------------------------------------
    task automatic read(input logic [2:0] sel, output logic [READ_W-1:0] d, output logic a, output bit ok);
        int n;
        @(negedge clk);
        rd_req = 1'b1;
        rd_sel = sel;
        @(negedge clk);
        rd_req = 1'b0;
        rd_sel = ~sel; // Stale select must not matter after the taking edge
        ok = 1'b0;
        for (n = 0; n < 4 && !ok; n++) begin
            if (rd_valid === 1'b1) ok = 1'b1;
            else @(negedge clk);
        end
        d = rd_data;
        a = rd_absent;
    endtask
endmodule
`default_nettype wire

// ---- verification/cir_regs_tb.sv ----
// Self-checking testbench for the card information register set
`timescale 1ns/1ps
`default_nettype none
module cir_regs_tb;
    import cir_pkg::*;
    localparam logic [7:0] MK = 8'hA5; // Arbitrary value
    localparam logic [15:0] OEM = 16'h1234; // Arbitrary value
    localparam logic [39:0] NM = 40'h0102030405;
    localparam logic [7:0] RV = 8'h21;
    localparam logic [31:0] SN = 32'h89ABCDEF;
    localparam logic [11:0] DT = 12'h3C7;
    localparam logic [8:0] WIN = 9'h155;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic capacity_pin = 1'b1;
    logic rd_req, rd_valid, rd_absent, card_ready;
    logic [2:0] rd_sel;
    logic [READ_W-1:0] rd_data, d;
    logic a;
    bit ok;
    int errors = 0;
    int comparisons = 0;

    // ----------------------------------------
    // Clock, design and host model
    // ----------------------------------------
    always #20 clk = ~clk;

    cir_regs #(.MAKER_CODE(MK), .OEM_CODE(OEM), .PRODUCT_NAME(NM), .PRODUCT_REV(RV), .PRODUCT_SERIAL(SN),
        .MANUFACTURE_DATE(DT), .VOLT_WINDOW(WIN), .PWRUP_COUNT(4), .SPECIFIC_DATA({SPECIFIC_W{1'b1}}),
        .CARD_ADDR(16'hFFFF), .CONFIG_DATA({CONFIG_W{1'b1}}), .STATUS_DATA({STATUS_W{1'b1}})) dut_u (
        .clk(clk), .rst(rst), .capacity_pin(capacity_pin), .rd_req(rd_req), .rd_sel(rd_sel),
        .rd_valid(rd_valid), .rd_absent(rd_absent), .rd_data(rd_data), .card_ready(card_ready));

    cir_host_model host_u (.clk(clk), .rd_valid(rd_valid), .rd_absent(rd_absent), .rd_data(rd_data),
        .rd_req(rd_req), .rd_sel(rd_sel));

    // ----------------------------------------
    // Reference checksum and compare tasks
    // ----------------------------------------
    function automatic logic [6:0] ref_crc(input logic [ID_BODY_W-1:0] body);
        logic [6:0] c;
        logic fb;
        c = 7'h00;
        for (int i = ID_BODY_W - 1; i >= 0; i--) begin
            fb = body[i] ^ c[6];
            c = {c[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
        end
        return c;
    endfunction

    task automatic conclude();
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check_word(input logic [READ_W-1:0] got, input logic [READ_W-1:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t: %s word mismatch", $time, what);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp, input string what);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t: %s flag mismatch", $time, what);
        end
    endtask

    // Read with timeout handling
    task automatic rd(input logic [2:0] sel);
        host_u.read(sel, d, a, ok);
        if (!ok) begin
            errors++;
            $display("ERROR at %0t: no answer strobe", $time);
            conclude();
        end
    endtask

    task automatic do_reset(input logic cap);
        @(negedge clk);
        rst = 1'b1;
        capacity_pin = cap;
        repeat (20) @(negedge clk);
        check_bit(card_ready, 1'b0, "reset ready");
        check_bit(rd_valid, 1'b0, "reset valid");
        rst = 1'b0;
    endtask

    task automatic wait_ready();
        int n;
        for (n = 0; n < 400 && card_ready !== 1'b1; n++) @(negedge clk);
        if (card_ready !== 1'b1) begin
            errors++;
            $display("ERROR at %0t: card never ready", $time);
            conclude();
        end
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [ID_BODY_W-1:0] body;
        logic [2:0] sels [4];
        int ws [4];
        sels = '{SEL_SPECIFIC, SEL_ADDR, SEL_CONFIG, SEL_STATUS};
        ws = '{SPECIFIC_W, ADDR_W, CONFIG_W, STATUS_W};
        body = {MK, OEM, NM, RV, SN, 4'h0, DT};
        do_reset(1'b1);
        rd(SEL_OPCOND);
        check_word(d, {WIN, 15'h0000}, "busy conditions");
        $display("Test busy conditions done");
        wait_ready();
        rd(SEL_OPCOND);
        check_word(d, {2'b11, 6'h00, WIN, 15'h0000}, "ready conditions");
        check_bit(d[31] & d[30], 1'b1, "capacity when ready");
        $display("Test ready conditions done");
        rd(SEL_IDENT);
        check_word(d, {body, ref_crc(body), 1'b1}, "identity");
        check_bit(a, 1'b0, "identity present");
        $display("Test identity done");
        for (int i = 0; i < 4; i++) begin
            rd(sels[i]);
            check_word(d, {READ_W{1'b1}} >> (READ_W - ws[i]), "width");
        end
        rd(SEL_DRIVER);
        check_bit(a, 1'b1, "driver absent");
        check_word(d, '0, "driver data");
        rd(3'h7);
        check_bit(a, 1'b1, "unused absent");
        $display("Test widths done");
        do_reset(1'b0);
        wait_ready();
        rd(SEL_OPCOND);
        check_word(d, {2'b10, 6'h00, WIN, 15'h0000}, "no capacity");
        $display("Test capacity clear done");
        conclude();
    end
endmodule
`default_nettype wire
